// ==== tac_acquire_ctrl.sv ====
// acquisition sequencer, plate driver and reference switch control
// assumes: serial clock and data arrive from pins, asynchronous to core_clk;
// the serial clock is much slower than core_clk so every edge is seen
`timescale 1ns/1ps
`include "tac_params.svh"

module tac_acquire_ctrl
  import tac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serial_conv_clock,
  input wire logic serial_data_in,
  output tac_drv_t panel_drv,
  output logic [2:0] mux_sel,
  output tac_ref_node_t ref_pos_sel,
  output tac_ref_node_t ref_neg_sel,
  output logic track_en,
  output logic conv_busy,
  output logic conv_8bit,
  output logic int_ref_en,
  output logic reference_isolation_switch,
  output logic diode_bias_en,
  output logic diode_bias_high
);

  // ==========================================================
  // decode functions
  // ==========================================================
  // plate drivers per channel; invalid codes drive nothing
  function automatic tac_drv_t drv_for(input logic [2:0] chan);
    tac_drv_t d;
    d = '0;
    if (chan == `TAC_CH_Y_POS) begin
      d.yp = 1'b1;
      d.yn = 1'b1;
    end else if (chan == `TAC_CH_Z1 || chan == `TAC_CH_Z2) begin
      d.yp = 1'b1;
      d.xn = 1'b1;
    end else if (chan == `TAC_CH_X_POS) begin
      d.xp = 1'b1;
      d.xn = 1'b1;
    end
    return d;
  endfunction : drv_for

  // positive reference node per channel and mode
  function automatic tac_ref_node_t refp_for(input logic [2:0] chan, input logic ser);
    tac_ref_node_t r;
    r = TAC_REF_VREF;
    if (!ser && (chan == `TAC_CH_Y_POS || chan == `TAC_CH_Z1 || chan == `TAC_CH_Z2)) begin
      r = TAC_REF_YP;
    end else if (!ser && chan == `TAC_CH_X_POS) begin
      r = TAC_REF_XP;
    end
    return r;
  endfunction : refp_for

  // negative reference node per channel and mode
  function automatic tac_ref_node_t refn_for(input logic [2:0] chan, input logic ser);
    tac_ref_node_t r;
    r = TAC_REF_GND;
    if (!ser && chan == `TAC_CH_Y_POS) begin
      r = TAC_REF_YN;
    end else if (!ser && (chan == `TAC_CH_Z1 || chan == `TAC_CH_Z2 || chan == `TAC_CH_X_POS)) begin
      r = TAC_REF_XN;
    end
    return r;
  endfunction : refn_for

  // power-down code that keeps the panel powered
  function automatic logic pd_keep(input logic [1:0] pd);
    return pd == `TAC_PD_KEEP_ON;
  endfunction : pd_keep

  // ==========================================================
  // pin synchronisers and serial edge detect
  // ==========================================================
  logic [2:0] sclk_sync_q; // [0] only feeds [1]
  logic [1:0] din_sync_q; // [0] only feeds [1]

  // two flops before any logic, third for edge detect
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_q <= 3'h0;
      din_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], serial_conv_clock};
      din_sync_q <= {din_sync_q[0], serial_data_in};
    end
  end

  // data and clock share latency, so data is stable at a rise
  wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  wire din_s = din_sync_q[1];

  // ==========================================================
  // state and counters
  // ==========================================================
  tac_state_t state_q, state_d; // sequencer state
  logic [4:0] fall_cnt_q; // falls since start bit
  logic [6:0] sreg_q; // control word shift register
  logic [4:0] conv_left_q; // result bits still to convert
  tac_word_t word_q; // word of the conversion in flight
  logic [1:0] pd_act_q; // power-down setting in force

  wire start_det = sclk_rise & din_s & (state_q == TAC_IDLE);
  wire at_track = sclk_fall & (state_q == TAC_WORD) & (fall_cnt_q == `TAC_TRACK_FALL - 5'h01);
  wire at_hold = sclk_fall & (state_q == TAC_ACQ) & (fall_cnt_q == `TAC_HOLD_FALL - 5'h01);
  wire conv_end = sclk_fall & (conv_left_q == 5'h01);
  // full word is in the shift register by the hold edge
  wire tac_word_t word_new = tac_word_t'(sreg_q);
  // at the track edge only channel and mode are in; reference mode lands on the next rise
  wire [2:0] chan_early = sreg_q[3:1];
  // sixth rise carries the reference mode bit
  wire at_ser = sclk_rise & (state_q == TAC_ACQ) & (fall_cnt_q == `TAC_TRACK_FALL);
  wire ser_early = din_s;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      TAC_IDLE: begin
        if (start_det) begin
          state_d = TAC_WORD;
        end
      end
      TAC_WORD: begin
        if (at_track) begin
          state_d = TAC_ACQ;
        end
      end
      TAC_ACQ: begin
        // edge counted, so a slow clock stretches this
        if (at_hold) begin
          state_d = TAC_IDLE;
        end
      end
      default: begin
        state_d = TAC_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TAC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // falling edge count and control word shift
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_cnt_q <= 5'h00;
      sreg_q <= 7'h00;
    end else if (start_det) begin
      fall_cnt_q <= 5'h00;
      sreg_q <= 7'h00;
    end else begin
      if (sclk_fall && state_q != TAC_IDLE) begin
        fall_cnt_q <= fall_cnt_q + 5'h01;
      end
      if (sclk_rise && state_q != TAC_IDLE) begin
        sreg_q <= {sreg_q[5:0], din_s};
      end
    end
  end

  // conversion bit countdown, independent of the next word so words may overlap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_left_q <= 5'h00;
      word_q <= '0;
    end else if (at_hold) begin
      conv_left_q <= word_new.mode8 ? `TAC_CONV_BITS_8 : `TAC_CONV_BITS_12;
      word_q <= word_new;
    end else if (sclk_fall && conv_left_q != 5'h00) begin
      conv_left_q <= conv_left_q - 5'h01;
    end
  end

  // ==========================================================
  // power-down and reference control
  // ==========================================================
  logic int_ref_en_q; // internal reference running
  logic iso_sw_q; // isolation switch closed

  // settings change only at conversion end, never mid-conversion
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_act_q <= `TAC_RESET_PD;
      int_ref_en_q <= 1'b0;
      iso_sw_q <= 1'b0;
    end else if (conv_end) begin
      pd_act_q <= word_q.pd;
      int_ref_en_q <= word_q.pd[`TAC_PD_REF_BIT];
      iso_sw_q <= word_q.pd[`TAC_PD_REF_BIT];
    end
  end

  // ==========================================================
  // panel drivers, multiplexer and reference nodes
  // ==========================================================
  tac_drv_t drv_q; // plate driver enables
  logic track_q; // track-and-hold tracking
  logic busy_q; // conversion in progress
  logic mode8_q; // 8-bit conversion selected
  logic [2:0] mux_q; // converter input select
  tac_ref_node_t refp_q, refn_q; // reference node sources
  logic bias_en_q, bias_high_q; // temperature diode bias

  // plate drivers; a new word overlapping a conversion keeps them on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_q <= '0;
    end else if (at_track) begin
      drv_q <= drv_for(chan_early);
    end else if (at_hold) begin
      if (word_new.ser && !pd_keep(word_new.pd)) begin
        drv_q <= '0;
      end
    end else if (conv_end) begin
      // next word pending keeps drivers on
      if (!pd_keep(word_q.pd) && state_q == TAC_IDLE) begin
        drv_q <= '0;
      end
    end
  end

  // tracking window and conversion busy; busy may drop on the edge a new word starts tracking
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      track_q <= 1'b0;
      busy_q <= 1'b0;
      mode8_q <= 1'b0;
    end else begin
      if (at_track) begin
        track_q <= 1'b1;
      end else if (at_hold) begin
        track_q <= 1'b0;
      end
      if (at_hold) begin
        busy_q <= 1'b1;
        mode8_q <= word_new.mode8;
      end else if (conv_end) begin
        busy_q <= 1'b0;
      end
    end
  end

  // input latched as tracking starts, references once the mode bit is in
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_q <= 3'h0;
      refp_q <= TAC_REF_VREF;
      refn_q <= TAC_REF_GND;
    end else begin
      if (at_track) begin
        mux_q <= chan_early;
      end
      if (at_ser) begin
        // reference nodes set by channel and the reference mode bit
        refp_q <= refp_for(chan_early, ser_early);
        refn_q <= refn_for(chan_early, ser_early);
      end
    end
  end

  // two temperature codes share one diode, biased differently
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bias_en_q <= 1'b0;
      bias_high_q <= 1'b0;
    end else if (at_ser) begin
      bias_en_q <= ser_early && (chan_early == `TAC_CH_TEMP_BASE || chan_early == `TAC_CH_TEMP_HIGH);
      bias_high_q <= ser_early && chan_early == `TAC_CH_TEMP_HIGH;
    end else if (at_hold) begin
      bias_en_q <= 1'b0;
      bias_high_q <= 1'b0;
    end
  end

  // outputs straight from flops
  assign panel_drv = drv_q;
  assign mux_sel = mux_q;
  assign ref_pos_sel = refp_q;
  assign ref_neg_sel = refn_q;
  assign track_en = track_q;
  assign conv_busy = busy_q;
  assign conv_8bit = mode8_q;
  assign int_ref_en = int_ref_en_q;
  assign reference_isolation_switch = iso_sw_q;
  assign diode_bias_en = bias_en_q;
  assign diode_bias_high = bias_high_q;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_hold_edge;
    $fell(track_q) ##0 (word_q.ser && !pd_keep(word_q.pd));
  endsequence

  property p_track_open;
    $rose(track_q) |-> $past(fall_cnt_q) == `TAC_TRACK_FALL - 5'h01 && $past(state_q) == TAC_WORD;
  endproperty
  a_track_open: assert property (p_track_open) else $error("tracking opened on wrong edge");

  property p_hold_edge;
    $fell(track_q) |-> $past(fall_cnt_q) == `TAC_HOLD_FALL - 5'h01 && busy_q;
  endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("hold began on wrong edge");

  property p_no_start_on_zero;
    (state_q == TAC_IDLE && sclk_rise && !din_s) |=> state_q == TAC_IDLE;
  endproperty
  a_no_start_on_zero: assert property (p_no_start_on_zero) else $error("zero taken as start");

  property p_se_drop;
    s_hold_edge |-> drv_q == '0;
  endproperty
  a_se_drop: assert property (p_se_drop) else $error("single-ended drivers left on");

  property p_ratio_hold;
    (busy_q && !word_q.ser && drv_for(mux_q) != '0 && state_q == TAC_IDLE) |-> drv_q == drv_for(mux_q);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratiometric drivers dropped");

  property p_keep_on;
    (conv_end && pd_keep(word_q.pd) && !at_track) |=> drv_q == $past(drv_q);
  endproperty
  a_keep_on: assert property (p_keep_on) else $error("keep-on setting powered down");

  property p_ref_follow;
    conv_end |=> int_ref_en_q == $past(word_q.pd[1]) ##1 $stable(int_ref_en_q);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference not set at end");

  property p_iso_sw;
    iso_sw_q == int_ref_en_q;
  endproperty
  a_iso_sw: assert property (p_iso_sw) else $error("isolation switch mismatched");

  property p_idle_dark;
    (state_q == TAC_IDLE && !busy_q && !pd_keep(pd_act_q) && !track_q) |-> drv_q == '0;
  endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("drivers on while idle");

  property p_diode;
    $rose(bias_high_q) |-> bias_en_q && mux_q == `TAC_CH_TEMP_HIGH && track_q;
  endproperty
  a_diode: assert property (p_diode) else $error("diode bias wrong");

endmodule : tac_acquire_ctrl

// ==== tac_acquire_ctrl_tb.sv ====
// self-checking bench for the acquire and reference control block
// assumes: host model drives the serial pins; one core clock at 250 MHz
`timescale 1ns/1ps
`include "tac_params.svh"

module tac_acquire_ctrl_tb;
  import tac_pkg::*;

  // one table row: control word and serial half period in core cycles
  typedef struct {
    tac_word_t w;
    int hp;
  } tac_row_t;

  logic core_clk;
  logic rst_b;
  wire logic sclk;
  wire logic sdata;
  int fall_n;
  tac_drv_t panel_drv;
  logic [2:0] mux_sel;
  tac_ref_node_t ref_pos_sel;
  tac_ref_node_t ref_neg_sel;
  logic track_en, conv_busy, conv_8bit, int_ref_en, iso_sw, bias_en, bias_high;
  int errors;
  int n_tests;

  // rows: chan, mode8, ser, pd; slow row stretches acquisition
  tac_row_t rows[9] = '{
    '{'{3'h1, 1'h0, 1'h1, 2'h0}, 6}, '{'{3'h1, 1'h0, 1'h0, 2'h0}, 6},
    '{'{3'h5, 1'h0, 1'h0, 2'h3}, 6}, '{'{3'h3, 1'h1, 1'h1, 2'h2}, 6},
    '{'{3'h4, 1'h0, 1'h0, 2'h1}, 6}, '{'{3'h0, 1'h0, 1'h1, 2'h0}, 6},
    '{'{3'h7, 1'h1, 1'h1, 2'h0}, 6}, '{'{3'h1, 1'h0, 1'h1, 2'h3}, 20},
    '{'{3'h6, 1'h0, 1'h1, 2'h2}, 6}};

  tac_acquire_ctrl tac_acquire_ctrl_i (
    .core_clk(core_clk), .rst_b(rst_b), .serial_conv_clock(sclk), .serial_data_in(sdata),
    .panel_drv(panel_drv), .mux_sel(mux_sel), .ref_pos_sel(ref_pos_sel), .ref_neg_sel(ref_neg_sel),
    .track_en(track_en), .conv_busy(conv_busy), .conv_8bit(conv_8bit), .int_ref_en(int_ref_en),
    .reference_isolation_switch(iso_sw), .diode_bias_en(bias_en), .diode_bias_high(bias_high));

  tac_host_model tac_host_model_i (.core_clk(core_clk), .sclk(sclk), .sdata(sdata), .fall_n(fall_n));

  // ==========================================================
  // expected plate drivers and reference nodes per channel
  // ==========================================================
  function automatic tac_drv_t exp_drv(input tac_word_t w);
    case (w.chan)
      3'h1: exp_drv = 4'h3; // both y plates
      3'h3, 3'h4: exp_drv = 4'h6; // y+ and x- for pressure
      3'h5: exp_drv = 4'hc; // both x plates
      default: exp_drv = 4'h0; // no panel channel
    endcase
  endfunction : exp_drv

  function automatic logic [5:0] exp_ref(input tac_word_t w);
    if (w.ser) begin
      return {TAC_REF_VREF, TAC_REF_GND};
    end
    case (w.chan)
      3'h1: return {TAC_REF_YP, TAC_REF_YN};
      3'h3, 3'h4: return {TAC_REF_YP, TAC_REF_XN};
      3'h5: return {TAC_REF_XP, TAC_REF_XN};
      default: return {TAC_REF_VREF, TAC_REF_GND};
    endcase
  endfunction : exp_ref

  // compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // bounded wait for serial fall k, then let the answer settle
  task automatic wait_fall(input int k);
    int t;
    t = 0;
    while (fall_n != k && t < 4000) begin
      @(negedge core_clk);
      t++;
    end
    if (t >= 4000) begin
      errors++;
      $display("MISMATCH fall_wait expected %0d seen %0d", k, fall_n);
      finish_test();
    end else begin
      repeat (5) @(negedge core_clk);
    end
  endtask : wait_fall

  // one whole conversion with checks at each event
  task automatic run_row(input tac_row_t r);
    int last;
    last = r.w.mode8 ? 16 : 20;
    fork
      tac_host_model_i.frame(r.w, last, r.hp);
      begin
        wait_fall(5);
        chk("track_open", 8'h1, 8'(track_en));
        chk("drv_acq", 8'(exp_drv(r.w)), 8'(panel_drv));
        chk("mux", 8'(r.w.chan), 8'(mux_sel));
        // reference mode bit is only in after the sixth rise
        wait_fall(7);
        chk("refs", 8'(exp_ref(r.w)), 8'({ref_pos_sel, ref_neg_sel}));
        chk("bias_en", 8'(r.w.ser && (r.w.chan == 3'h0 || r.w.chan == 3'h7)), 8'(bias_en));
        chk("bias_high", 8'(r.w.ser && r.w.chan == 3'h7), 8'(bias_high));
        chk("track_hold", 8'h1, 8'(track_en));
        wait_fall(8);
        chk("track_end", 8'h0, 8'(track_en));
        chk("busy", 8'h1, 8'(conv_busy));
        chk("mode8", 8'(r.w.mode8), 8'(conv_8bit));
        chk("drv_conv", (r.w.ser && r.w.pd != 2'h3) ? 8'h0 : 8'(exp_drv(r.w)), 8'(panel_drv));
        wait_fall(last - 1);
        chk("busy_tail", 8'h1, 8'(conv_busy));
        wait_fall(last);
        chk("busy_end", 8'h0, 8'(conv_busy));
        chk("ref_en", 8'(r.w.pd[1]), 8'(int_ref_en));
        chk("iso_sw", 8'(r.w.pd[1]), 8'(iso_sw));
        chk("drv_end", (r.w.pd == 2'h3) ? 8'(exp_drv(r.w)) : 8'h0, 8'(panel_drv));
      end
    join
  endtask : run_row

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    tac_word_t a;
    tac_word_t b;
    errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("rst_drv", 8'h0, 8'(panel_drv));
    chk("rst_refs", 8'({TAC_REF_VREF, TAC_REF_GND}), 8'({ref_pos_sel, ref_neg_sel}));
    chk("rst_iso", 8'h0, 8'(iso_sw));
    // idle pulses with data low start nothing
    tac_host_model_i.idle_clocks(10);
    repeat (5) @(negedge core_clk);
    chk("idle_track", 8'h0, 8'(track_en));
    chk("idle_busy", 8'h0, 8'(conv_busy));
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // overlapped words: next start lands inside the conversion
    a = '{3'h1, 1'h0, 1'h0, 2'h0};
    b = '{3'h5, 1'h0, 1'h0, 2'h0};
    fork
      begin
        tac_host_model_i.frame(a, 15, 6);
        tac_host_model_i.frame(b, 20, 6);
      end
      begin
        wait_fall(15);
        wait_fall(4);
        chk("ovl_busy", 8'h1, 8'(conv_busy));
        chk("ovl_drv", 8'(exp_drv(a)), 8'(panel_drv));
        wait_fall(5);
        chk("ovl_next", 8'(exp_drv(b)), 8'(panel_drv));
        chk("ovl_track", 8'h1, 8'(track_en));
        chk("ovl_gap", 8'h0, 8'(conv_busy));
        wait_fall(20);
        chk("ovl_off", 8'h0, 8'(panel_drv));
      end
    join
    finish_test();
  end
endmodule : tac_acquire_ctrl_tb

// ==== tac_host_model.sv ====
// host side model: drives the serial clock and the control word pins
// assumes: pins change on the falling edge of the bench core_clk
`timescale 1ns/1ps

module tac_host_model
  import tac_pkg::*;
(
  input wire logic core_clk,
  output logic sclk,
  output logic sdata,
  output int fall_n
);
  // serial clock rests low outside frames, except for the idle_clocks pulses
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    fall_n = 0;
  end

  // ==========================================================
  // frame: start bit, seven control bits, then low data
  // ==========================================================
  // start bit one; pd rides in every word; hp slows clock
  task automatic frame(input tac_word_t w, input int nfalls, input int hp);
    logic [7:0] bits;
    // fall count is left standing between frames so a waiter cannot miss the last one
    bits = {1'b1, w};
    for (int i = 0; i < nfalls; i++) begin
      @(negedge core_clk);
      sdata = (i < 8) ? bits[7 - i] : 1'b0;
      repeat (hp) @(negedge core_clk);
      sclk = 1'b1;
      repeat (hp) @(negedge core_clk);
      sclk = 1'b0;
      fall_n = i + 1;
    end
    // released line shows the inverse, not a held value
    sdata = ~sdata;
  endtask : frame

  // clock pulses with data low while idle
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      sdata = 1'b0;
      repeat (6) @(negedge core_clk);
      sclk = 1'b1;
      repeat (6) @(negedge core_clk);
      sclk = 1'b0;
    end
  endtask : idle_clocks
endmodule : tac_host_model

// ==== tac_params.svh ====
// constants for the touch converter acquire and reference control block
// assumes: counts are in falling edges of the host serial clock, not core cycles
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH

// ==========================================================
// acquisition timing, in serial clock falling edges
// ==========================================================
// tracking opens on this falling edge after the start bit
`define TAC_TRACK_FALL 5'h05
// sampling window length before hold
`define TAC_ACQ_CYCLES 5'h03
// falling edge on which hold begins
`define TAC_HOLD_FALL (`TAC_TRACK_FALL + `TAC_ACQ_CYCLES)

// ==========================================================
// conversion lengths, one result bit per falling edge
// ==========================================================
`define TAC_CONV_BITS_12 5'h0c
`define TAC_CONV_BITS_8 5'h08

// ==========================================================
// control word fields after the start bit, msb first
// ==========================================================
`define TAC_WORD_BITS 7
`define TAC_PD_KEEP_ON 2'h3
`define TAC_PD_REF_BIT 1
`define TAC_RESET_PD 2'h0

// ==========================================================
// channel select codes
// ==========================================================
`define TAC_CH_TEMP_BASE 3'h0
`define TAC_CH_Y_POS 3'h1
`define TAC_CH_Z1 3'h3
`define TAC_CH_Z2 3'h4
`define TAC_CH_X_POS 3'h5
`define TAC_CH_TEMP_HIGH 3'h7

`endif

// ==== tac_pkg.sv ====
// types shared by the touch converter acquire and reference control block
// assumes: constants live in tac_params.svh
package tac_pkg;

  // ==========================================================
  // sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    TAC_IDLE,
    TAC_WORD,
    TAC_ACQ
  } tac_state_t;

  // ==========================================================
  // panel plate driver enables
  // ==========================================================
  typedef struct packed {
    logic xp;
    logic xn;
    logic yp;
    logic yn;
  } tac_drv_t;

  // converter reference node sources
  typedef enum logic [2:0] {
    TAC_REF_VREF,
    TAC_REF_GND,
    TAC_REF_YP,
    TAC_REF_YN,
    TAC_REF_XP,
    TAC_REF_XN
  } tac_ref_node_t;

  // control word after the start bit, same order as shifted in
  typedef struct packed {
    logic [2:0] chan;
    logic mode8;
    logic ser;
    logic [1:0] pd;
  } tac_word_t;

endpackage : tac_pkg
